/* verilog/stamp_map.svh */
// Notes on behaviour
// - Stamp is 56-bit count in 64-bit word
// - Count per sample clock; clear restarts count
// - Store count at internal trigger moment
// - All modes zero top byte unless capture flag set
// - Refclock mode: 24-bit edges over 32-bit samples
// - Capture flag puts aux inputs in top byte
// - Writing 4096 enables aux input capture
// - Capture bit zero zero-fills top byte
// - Format bit independent of mode bits
// - One stamp per trigger in segmented mode
// - Stamp marks trigger, not segment start
// - Gate length rounds up to a multiple of 4, 2 or 1 for 1, 2 or 4 channels
// - Gate padding never alters stamp values
`ifndef STAMP_MAP_SVH
`define STAMP_MAP_SVH
`define ADDR_STAMP_COMMAND 16'hb7fc
`define ADDR_STAMP_STATUS 16'hb800
`define ADDR_STAMP_LOW 16'hb804
`define ADDR_STAMP_HIGH 16'hb808
`define ADDR_GATE_LEN 16'hb80c
`define CMD_RESET 32'h00000000
`define CMD_MODE_LSB 0
`define CMD_MODE_MSB 1
`define CMD_CLEAR_BIT 2
`define CMD_SEGMENTED_BIT 3
`define CMD_CHAN_LSB 4
`define CMD_CHAN_MSB 5
`define CMD_AUX_BIT 12
`define CMD_WRITE_MASK 32'h0000103f
`define STAMP_WIDTH 56
`define WORD_WIDTH 64
`define REF_WIDTH 24
`define SAMPLE_WIDTH 32
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

/* verilog/stamp_pkg.sv */
package stamp_pkg;
    typedef enum logic [1:0] {
        MODE_STANDARD = 2'b00,
        MODE_START_CLEARED = 2'b01,
        MODE_REFCLOCK = 2'b11
    } stamp_mode_t;
    typedef enum logic [1:0] {
        CH_ONE = 2'b00,
        CH_TWO = 2'b01,
        CH_FOUR = 2'b11
    } chan_count_t;
    typedef enum logic [1:0] {
        GATE_IDLE = 2'b00,
        GATE_OPEN = 2'b01,
        GATE_PAD = 2'b11
    } gate_state_t;
endpackage : stamp_pkg

/* verilog/stamp_ram.sv */
`timescale 1ns/10ps
`include "stamp_map.svh"
module stamp_ram (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [`FIFO_AW-1:0] wr_addr,
    input wire logic [`WORD_WIDTH-1:0] wr_data,
    input wire logic [`FIFO_AW-1:0] rd_addr,
    output logic [`WORD_WIDTH-1:0] rd_data
);
    logic [`WORD_WIDTH-1:0] mem [0:`FIFO_DEPTH-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read keeps the pop path to one flop stage
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule : stamp_ram

/* verilog/sync3.sv */
`timescale 1ns/10ps
module sync3 #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // A change counts only once the last two stages agree
            if (s2_reg == s3_reg) begin
                q <= s3_reg;
            end
        end
    end
endmodule : sync3

/* verilog/trigger_timestamp_formatter.sv */
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "stamp_map.svh"
module trigger_timestamp_formatter (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SAMPLE_EN,
    input wire logic REF_EDGE,
    input wire logic TRIGGER,
    input wire logic GATE,
    input wire logic [7:0] AUX_DIGITAL_INPUTS,
    output logic GATE_PAD_ACTIVE
);
    logic [31:0] command_reg;
    logic [`STAMP_WIDTH-1:0] count_reg;
    logic [`STAMP_WIDTH-1:0] count_next;
    logic [`SAMPLE_WIDTH-1:0] gate_len_reg;
    logic [31:0] last_gate_reg;
    logic [1:0] pad_reg;
    logic [7:0] aux_sync;
    logic trig_d_reg;
    logic gate_d_reg;
    logic ref_d_reg;
    logic [`FIFO_AW:0] wr_ptr_reg;
    logic [`FIFO_AW:0] rd_ptr_reg;
    logic [`WORD_WIDTH-1:0] rd_data;
    logic [`WORD_WIDTH-1:0] head_reg;
    logic [`WORD_WIDTH-1:0] stamp_word;
    logic push;
    logic pop;
    logic fifo_full;
    logic fifo_empty;
    logic overrun_reg;
    logic apb_wr;
    logic apb_rd;
    logic trig_rise;
    logic gate_edge;
    logic ref_rise;
    stamp_pkg::gate_state_t gate_state_reg;
    stamp_pkg::stamp_mode_t mode;
    stamp_pkg::chan_count_t chans;

    function automatic logic [1:0] align_mask(input stamp_pkg::chan_count_t c);
        case (c)
            stamp_pkg::CH_ONE: align_mask = 2'h3;
            stamp_pkg::CH_TWO: align_mask = 2'h1;
            default: align_mask = 2'h0;
        endcase
    endfunction : align_mask

    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        hit = (a == b);
    endfunction : hit

    sync3 #(.W(8)) i_sync3 (
        .clk(CLOCK),
        .rst_n(RST_N),
        .d(AUX_DIGITAL_INPUTS),
        .q(aux_sync)
    );

    assign mode = stamp_pkg::stamp_mode_t'(command_reg[`CMD_MODE_MSB:`CMD_MODE_LSB]);
    assign chans = stamp_pkg::chan_count_t'(command_reg[`CMD_CHAN_MSB:`CMD_CHAN_LSB]);
    assign apb_wr = PSEL && PENABLE && PWRITE && PREADY;
    assign apb_rd = PSEL && PENABLE && !PWRITE && PREADY;
    assign trig_rise = TRIGGER && !trig_d_reg;
    assign gate_edge = GATE != gate_d_reg;
    assign ref_rise = REF_EDGE && !ref_d_reg;

    // Command register; bit 12 is the aux capture flag, the clear bit drops back to zero after one cycle
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            command_reg <= `CMD_RESET;
        end else if (apb_wr && hit(PADDR, `ADDR_STAMP_COMMAND)) begin
            command_reg <= PWDATA & `CMD_WRITE_MASK;
        end else begin
            command_reg[`CMD_CLEAR_BIT] <= 1'b0;
        end
    end

    always_comb begin
        count_next = count_reg;
        if (command_reg[`CMD_CLEAR_BIT]) begin
            count_next = '0;
        end else if (mode == stamp_pkg::MODE_REFCLOCK) begin
            if (ref_rise) begin
                count_next = {count_reg[`STAMP_WIDTH-1:`SAMPLE_WIDTH] + 24'h000001,
                              32'h00000000};
            end else if (SAMPLE_EN) begin
                count_next[`SAMPLE_WIDTH-1:0] = count_reg[`SAMPLE_WIDTH-1:0] + 32'h00000001;
            end
        end else if (SAMPLE_EN) begin
            count_next = count_reg + 56'h00000000000001;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            trig_d_reg <= 1'b0;
            gate_d_reg <= 1'b0;
            ref_d_reg <= 1'b0;
        end else begin
            trig_d_reg <= TRIGGER;
            gate_d_reg <= GATE;
            ref_d_reg <= REF_EDGE;
        end
    end

    // Stamp is the live count at the internal trigger edge, fixed lag
    assign stamp_word = {command_reg[`CMD_AUX_BIT] ? aux_sync : 8'h00, count_reg};
    // One push per trigger edge; gate edges stamp too, padding never does
    assign push = (trig_rise || gate_edge) && !fifo_full;
    assign pop = apb_rd && hit(PADDR, `ADDR_STAMP_HIGH) && !fifo_empty;
    assign fifo_full = (wr_ptr_reg[`FIFO_AW-1:0] == rd_ptr_reg[`FIFO_AW-1:0]) &&
                       (wr_ptr_reg[`FIFO_AW] != rd_ptr_reg[`FIFO_AW]);
    assign fifo_empty = wr_ptr_reg == rd_ptr_reg;

    stamp_ram i_stamp_ram (
        .clk(CLOCK),
        .wr_en(push),
        .wr_addr(wr_ptr_reg[`FIFO_AW-1:0]),
        .wr_data(stamp_word),
        .rd_addr(rd_ptr_reg[`FIFO_AW-1:0]),
        .rd_data(rd_data)
    );

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            overrun_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 5'h01;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 5'h01;
            end
            // Set wins over the clear by write
            if ((trig_rise || gate_edge) && fifo_full) begin
                overrun_reg <= 1'b1;
            end else if (apb_wr && hit(PADDR, `ADDR_STAMP_STATUS) && PWDATA[0]) begin
                overrun_reg <= 1'b0;
            end
        end
    end

    // Head word tracks RAM output two cycles after a pointer move
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            head_reg <= '0;
        end else begin
            head_reg <= rd_data;
        end
    end

    // Gate length counter with end padding to the channel alignment
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            gate_state_reg <= stamp_pkg::GATE_IDLE;
            gate_len_reg <= '0;
            pad_reg <= '0;
            last_gate_reg <= '0;
        end else begin
            case (gate_state_reg)
                stamp_pkg::GATE_IDLE: begin
                    if (GATE && !gate_d_reg) begin
                        gate_state_reg <= stamp_pkg::GATE_OPEN;
                        gate_len_reg <= '0;
                    end
                end
                stamp_pkg::GATE_OPEN: begin
                    // A sample in the closing cycle is outside the gate
                    if (SAMPLE_EN && GATE) begin
                        gate_len_reg <= gate_len_reg + 32'h00000001;
                    end
                    if (!GATE) begin
                        pad_reg <= align_mask(chans) & (2'h0 - gate_len_reg[1:0]);
                        gate_state_reg <= stamp_pkg::GATE_PAD;
                    end
                end
                stamp_pkg::GATE_PAD: begin
                    if (pad_reg == 2'h0) begin
                        last_gate_reg <= gate_len_reg;
                        gate_state_reg <= stamp_pkg::GATE_IDLE;
                    end else if (SAMPLE_EN) begin
                        pad_reg <= pad_reg - 2'h1;
                        gate_len_reg <= gate_len_reg + 32'h00000001;
                    end
                end
                default: gate_state_reg <= stamp_pkg::GATE_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            GATE_PAD_ACTIVE <= 1'b0;
        end else begin
            GATE_PAD_ACTIVE <= gate_state_reg == stamp_pkg::GATE_PAD && pad_reg != 2'h0;
        end
    end

    // APB: no wait states; read data staged in the setup cycle
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= '0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            if (PSEL && !PENABLE) begin
                PSLVERR <= !(hit(PADDR, `ADDR_STAMP_COMMAND) || hit(PADDR, `ADDR_STAMP_STATUS) ||
                             hit(PADDR, `ADDR_STAMP_LOW) || hit(PADDR, `ADDR_STAMP_HIGH) ||
                             hit(PADDR, `ADDR_GATE_LEN));
                case (PADDR)
                    `ADDR_STAMP_COMMAND: PRDATA <= command_reg;
                    `ADDR_STAMP_STATUS: PRDATA <= {26'h0, overrun_reg, fifo_full,
                                                   fifo_empty, 3'h0} | {31'h0, overrun_reg};
                    `ADDR_STAMP_LOW: PRDATA <= head_reg[31:0];
                    `ADDR_STAMP_HIGH: PRDATA <= head_reg[63:32];
                    `ADDR_GATE_LEN: PRDATA <= last_gate_reg;
                    default: PRDATA <= 32'h00000000;
                endcase
            end
        end
    end

    property p_zero_fill;
        @(posedge CLOCK) disable iff (!RST_N)
        push && !command_reg[`CMD_AUX_BIT] |-> stamp_word[63:56] == 8'h00;
    endproperty
    a_zero_fill: assert property (p_zero_fill) else $error("top byte not zero");

    property p_aux_fill;
        @(posedge CLOCK) disable iff (!RST_N)
        push && command_reg[`CMD_AUX_BIT] |-> stamp_word[63:56] == aux_sync;
    endproperty
    a_aux_fill: assert property (p_aux_fill) else $error("top byte not aux");

    property p_stamp_count;
        @(posedge CLOCK) disable iff (!RST_N)
        push |-> stamp_word[55:0] == count_reg;
    endproperty
    a_stamp_count: assert property (p_stamp_count) else $error("stamp not count");

    property p_clear;
        @(posedge CLOCK) disable iff (!RST_N)
        command_reg[`CMD_CLEAR_BIT] |=> count_reg == 56'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("count not cleared");

    property p_inc;
        @(posedge CLOCK) disable iff (!RST_N)
        SAMPLE_EN && mode != stamp_pkg::MODE_REFCLOCK && !command_reg[`CMD_CLEAR_BIT]
        |=> count_reg == $past(count_reg) + 56'h1;
    endproperty
    a_inc: assert property (p_inc) else $error("count not incremented");

    property p_one_push;
        @(posedge CLOCK) disable iff (!RST_N)
        trig_rise && !fifo_full |=> wr_ptr_reg == $past(wr_ptr_reg) + 5'h01;
    endproperty
    a_one_push: assert property (p_one_push) else $error("trigger not stamped");

    property p_aux_bit;
        @(posedge CLOCK) disable iff (!RST_N)
        apb_wr && hit(PADDR, `ADDR_STAMP_COMMAND) |=> command_reg[`CMD_AUX_BIT] == $past(PWDATA[12]);
    endproperty
    a_aux_bit: assert property (p_aux_bit) else $error("aux bit not at 12");

    property p_pad_no_push;
        @(posedge CLOCK) disable iff (!RST_N)
        gate_state_reg == stamp_pkg::GATE_PAD && !trig_rise && !gate_edge |=> wr_ptr_reg == $past(wr_ptr_reg);
    endproperty
    a_pad_no_push: assert property (p_pad_no_push) else $error("padding pushed stamp");

    property p_align;
        @(posedge CLOCK) disable iff (!RST_N)
        gate_state_reg == stamp_pkg::GATE_PAD && pad_reg == 2'h0 && chans == stamp_pkg::CH_ONE
        |-> gate_len_reg[1:0] == 2'h0;
    endproperty
    a_align: assert property (p_align) else $error("gate not aligned");

    property p_align_two;
        @(posedge CLOCK) disable iff (!RST_N)
        gate_state_reg == stamp_pkg::GATE_PAD && pad_reg == 2'h0 && chans == stamp_pkg::CH_TWO
        |-> gate_len_reg[0] == 1'b0;
    endproperty
    a_align_two: assert property (p_align_two) else $error("gate not two aligned");

    property p_pad_count;
        @(posedge CLOCK) disable iff (!RST_N)
        gate_state_reg == stamp_pkg::GATE_PAD && pad_reg != 2'h0 && SAMPLE_EN
        |=> gate_len_reg == $past(gate_len_reg) + 32'h1 && pad_reg == $past(pad_reg) - 2'h1;
    endproperty
    a_pad_count: assert property (p_pad_count) else $error("padding sample not counted");

    property p_ref_edge;
        @(posedge CLOCK) disable iff (!RST_N)
        mode == stamp_pkg::MODE_REFCLOCK && ref_rise && !command_reg[`CMD_CLEAR_BIT]
        |=> count_reg[31:0] == 32'h0 && count_reg[55:32] == $past(count_reg[55:32]) + 24'h1;
    endproperty
    a_ref_edge: assert property (p_ref_edge) else $error("ref edge not counted");

    property p_ref_sample;
        @(posedge CLOCK) disable iff (!RST_N)
        mode == stamp_pkg::MODE_REFCLOCK && SAMPLE_EN && !ref_rise &&
        !command_reg[`CMD_CLEAR_BIT]
        |=> count_reg[31:0] == $past(count_reg[31:0]) + 32'h1 &&
        count_reg[55:32] == $past(count_reg[55:32]);
    endproperty
    a_ref_sample: assert property (p_ref_sample) else $error("sample field not counted");

    // Without a sample, a clear or a reference edge the count must stand still
    property p_hold;
        @(posedge CLOCK) disable iff (!RST_N)
        !SAMPLE_EN && !command_reg[`CMD_CLEAR_BIT] &&
        !(mode == stamp_pkg::MODE_REFCLOCK && ref_rise)
        |=> count_reg == $past(count_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without sample");

    property p_overrun_set;
        @(posedge CLOCK) disable iff (!RST_N)
        (trig_rise || gate_edge) && fifo_full |=> overrun_reg &&
        wr_ptr_reg == $past(wr_ptr_reg);
    endproperty
    a_overrun_set: assert property (p_overrun_set) else $error("lost stamp not flagged");

    property p_mode_write;
        @(posedge CLOCK) disable iff (!RST_N)
        apb_wr && hit(PADDR, `ADDR_STAMP_COMMAND)
        |=> command_reg[1:0] == $past(PWDATA[1:0]) && command_reg[12] == $past(PWDATA[12]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode and format split");
endmodule : trigger_timestamp_formatter

/* verif/apb_host.sv */
`timescale 1ns/10ps
module apb_host (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [15:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h00000000;
    end

    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Request stands until the rising edge that samples pready high
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host

/* verif/trigger_timestamp_formatter_tb.sv */
`timescale 1ns/10ps
`include "stamp_map.svh"
module trigger_timestamp_formatter_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, pad;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic sample_en = 1'b0;
    logic ref_edge = 1'b0;
    logic trigger = 1'b0;
    logic gate = 1'b0;
    logic [7:0] aux = 8'h00;
    logic e;
    logic [63:0] s;
    int n_mismatch = 0;
    int total_checks = 0;

    always #50 clock = ~clock;

    trigger_timestamp_formatter i_trigger_timestamp_formatter (
        .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SAMPLE_EN(sample_en), .REF_EDGE(ref_edge), .TRIGGER(trigger),
        .GATE(gate), .AUX_DIGITAL_INPUTS(aux), .GATE_PAD_ACTIVE(pad)
    );

    apb_host i_apb_host (
        .clk(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    task automatic tally_and_finish;
        $display("Checks made %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    task automatic samp(input int n);
        repeat (n) begin
            @(posedge clock);
            sample_en <= 1'b1;
            @(posedge clock);
            sample_en <= 1'b0;
        end
    endtask : samp

    task automatic edge_on(input bit t);
        @(posedge clock);
        if (t) trigger <= 1'b1;
        else ref_edge <= 1'b1;
        cyc(2);
        trigger <= 1'b0;
        ref_edge <= 1'b0;
        cyc(2);
    endtask : edge_on

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        i_apb_host.xfer(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [15:0] a);
        i_apb_host.xfer(1'b0, a, 32'h00000000, r, e);
    endtask : rd

    // Reading the high word pops, so the head needs a few cycles to refresh
    task automatic get;
        rd(`ADDR_STAMP_LOW);
        s[31:0] = r;
        rd(`ADDR_STAMP_HIGH);
        s[63:32] = r;
        cyc(3);
    endtask : get

    task automatic t_regs;
        rd(`ADDR_STAMP_COMMAND);
        chk(64'h0, 64'(r));
        rd(16'hb810);
        chk(64'h1, 64'(e));
        chk(64'h0, 64'(r));
    endtask : t_regs

    task automatic t_formats;
        @(posedge clock);
        aux <= 8'ha5;
        wr(`ADDR_STAMP_COMMAND, 32'h00001004);
        cyc(6);
        samp(6);
        edge_on(1'b1);
        get();
        chk({8'ha5, 56'd6}, s);
        rd(`ADDR_STAMP_COMMAND);
        chk(64'h1000, 64'(r));
        wr(`ADDR_STAMP_COMMAND, 32'h00000005);
        cyc(4);
        samp(2);
        edge_on(1'b1);
        get();
        chk({8'h00, 56'd2}, s);
    endtask : t_formats

    task automatic t_segments;
        int d[3] = '{3, 2, 4};
        int acc;
        acc = 0;
        wr(`ADDR_STAMP_COMMAND, 32'h0000000c);
        cyc(4);
        for (int i = 0; i < 3; i++) begin
            samp(d[i]);
            edge_on(1'b1);
        end
        for (int i = 0; i < 3; i++) begin
            acc += d[i];
            get();
            chk(64'(acc), s);
        end
        rd(`ADDR_STAMP_STATUS);
        chk(64'h1, 64'(r[3]));
    endtask : t_segments

    task automatic t_gates;
        logic [1:0] ch[3] = '{2'b00, 2'b01, 2'b11};
        int al[3] = '{4, 2, 1};
        for (int i = 0; i < 3; i++) begin
            wr(`ADDR_STAMP_COMMAND, 32'h4 | (32'(ch[i]) << 4));
            cyc(4);
            gate <= 1'b1;
            cyc(2);
            samp(5);
            cyc(1);
            gate <= 1'b0;
            cyc(3);
            chk(64'(al[i] > 1), 64'(pad));
            samp(4);
            cyc(4);
            chk(64'h0, 64'(pad));
            get();
            chk(64'd0, s);
            get();
            chk(64'd5, s);
            rd(`ADDR_GATE_LEN);
            chk(64'((5 + al[i] - 1) / al[i] * al[i]), 64'(r));
        end
    endtask : t_gates

    task automatic t_refclock;
        wr(`ADDR_STAMP_COMMAND, 32'h00001007);
        cyc(4);
        samp(3);
        edge_on(1'b0);
        samp(2);
        edge_on(1'b0);
        samp(4);
        edge_on(1'b1);
        get();
        chk({8'ha5, 24'd2, 32'd4}, s);
    endtask : t_refclock

    // Seventeen triggers into sixteen slots: the last one is lost and flagged
    task automatic t_overrun;
        wr(`ADDR_STAMP_COMMAND, 32'h00000004);
        cyc(4);
        repeat (17) edge_on(1'b1);
        rd(`ADDR_STAMP_STATUS);
        chk(64'h31, 64'(r));
        wr(`ADDR_STAMP_STATUS, 32'h00000001);
        rd(`ADDR_STAMP_STATUS);
        chk(64'h10, 64'(r));
    endtask : t_overrun

    initial begin
        cyc(8);
        rst_n <= 1'b1;
        cyc(1);
        t_regs();
        t_formats();
        t_segments();
        t_gates();
        t_refclock();
        t_overrun();
        tally_and_finish();
    end

    initial begin
        cyc(5000);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : trigger_timestamp_formatter_tb
